//--- rtl/mcuio_pkg.sv
// package for the motor controller user i/o and analog routing block
// assumes a single 100 MHz clock and a plain register port
package mcuio_pkg;

  // =====================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ANA12   = 8'h08;
  localparam logic [7:0] OFS_ANA34   = 8'h0c;
  localparam logic [7:0] OFS_INT_ST  = 8'h10;
  localparam logic [7:0] OFS_INT_EN  = 8'h14;
  localparam logic [7:0] OFS_INT_CLR = 8'h18;
  localparam logic [7:0] OFS_CMD     = 8'h1c;
  localparam logic [7:0] OFS_THERM   = 8'h20;

  // =====================================================
  // control field positions
  localparam int CTRL_MODE_LSB   = 0;  // 3 bits operating mode
  localparam int CTRL_LOOP_LSB   = 3;  // 2 bits loop kind
  localparam int CTRL_SOI_LSB    = 5;  // 2 bits stop_or_invert function
  localparam int CTRL_AUTO_BIT   = 7;  // accessory on while motor powered
  localparam int CTRL_THERM_BIT  = 8;  // thermistor fitted
  localparam int CTRL_TSEL_LSB   = 9;  // 2 bits thermistor input select
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // =====================================================
  // command codes written to the command register
  localparam logic [7:0] CMD_ACC_ON  = 8'h43;  // upper case output command
  localparam logic [7:0] CMD_ACC_OFF = 8'h63;  // lower case output command

  // =====================================================
  // reply codes and numeric constants
  localparam logic [7:0] REPLY_OFF   = 8'h00;
  localparam logic [7:0] REPLY_ON    = 8'h01;
  localparam logic [7:0] ADC_OFFSET  = 8'h80;  // 128
  localparam logic [7:0] RC3_ON_LEVEL = 8'h80;
  localparam logic [7:0] THERM_HOT_DEFAULT = 8'h40;
  localparam logic [7:0] THERM_DERATE_DEFAULT = 8'h40;

  // =====================================================
  // interrupt bit positions
  localparam int IRQ_STOP   = 0;
  localparam int IRQ_INV    = 1;
  localparam int IRQ_GPIN   = 2;
  localparam int IRQ_HOT    = 3;
  localparam int IRQ_W      = 4;

  // =====================================================
  // types
  typedef enum logic [2:0] {
    MCUIO_RC_DUAL, MCUIO_SER_DUAL, MCUIO_ANA_DUAL, MCUIO_SINGLE, MCUIO_MIXED
  } mcuio_mode_e;

  typedef enum logic [1:0] {MCUIO_OPEN, MCUIO_POS, MCUIO_SPEED} mcuio_loop_e;

  typedef enum logic [1:0] {MCUIO_NOACT, MCUIO_ESTOP, MCUIO_INVERT} mcuio_soi_e;

  typedef enum logic [1:0] {
    MCUIO_ROLE_UNUSED, MCUIO_ROLE_CMD, MCUIO_ROLE_FB
  } mcuio_role_e;

  typedef struct packed {
    logic [7:0] rdy;
    logic       ack;
  } mcuio_dummy_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mcuio_bus_s;

  typedef struct packed {
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    logic [7:0] a4;
  } mcuio_ana_s;

endpackage

//--- rtl/mcuio_top.sv
// user i/o and analog routing of a dual channel motor controller
// assumes converter samples arrive synchronous to mclk, pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module mcuio_top
  import mcuio_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // register port
  input  wire mcuio_bus_s  bus,
  output logic [31:0]      rdata,
  // pins
  input  wire logic        gp_input_pin,
  input  wire logic        stop_or_invert_input,
  input  wire logic [7:0]  rc_ch3_level,
  output logic             acc_out,
  output logic             acc_out_oe,
  // analog samples, unsigned converter results
  input  wire mcuio_ana_s  ana_raw,
  // motor side
  input  wire logic        motor_powered,
  output logic             drive_enable,
  output logic             controls_inverted,
  output logic             power_derate,
  output logic [7:0]       speed1_fb,
  output logic [7:0]       speed2_fb,
  output logic [7:0]       pos1_fb,
  output logic [7:0]       pos2_fb,
  // interrupt
  output logic             irq
);

  // =====================================================
  // synchronisers, three stages, second and third agree
  logic [2:0] gp_sync;
  logic [2:0] soi_sync;
  logic       gp_level;
  logic       soi_level;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gp_sync  <= 3'h0;
      soi_sync <= 3'h7;
      gp_level <= 1'b0;
      soi_level <= 1'b1;
    end else begin
      gp_sync  <= {gp_sync[1:0], gp_input_pin};
      soi_sync <= {soi_sync[1:0], stop_or_invert_input};
      if (gp_sync[2] == gp_sync[1])
        gp_level <= gp_sync[2];
      if (soi_sync[2] == soi_sync[1])
        soi_level <= soi_sync[2];
    end
  end

  // =====================================================
  // control register
  logic [31:0] ctrl;
  mcuio_mode_e mode;
  mcuio_loop_e loop_kind;
  mcuio_soi_e  soi_fn;
  logic        auto_acc;
  logic        therm_en;
  logic [1:0]  therm_sel;
  logic [7:0]  therm_hot;

  assign mode      = mcuio_mode_e'(ctrl[CTRL_MODE_LSB +: 3]);
  assign loop_kind = mcuio_loop_e'(ctrl[CTRL_LOOP_LSB +: 2]);
  assign soi_fn    = mcuio_soi_e'(ctrl[CTRL_SOI_LSB +: 2]);
  assign auto_acc  = ctrl[CTRL_AUTO_BIT];
  assign therm_en  = ctrl[CTRL_THERM_BIT];
  assign therm_sel = ctrl[CTRL_TSEL_LSB +: 2];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl      <= CTRL_RESET;
      therm_hot <= THERM_HOT_DEFAULT;
    end else if (bus.wr) begin
      if (bus.addr == OFS_CTRL)
        ctrl <= bus.wdata;
      if (bus.addr == OFS_THERM)
        therm_hot <= bus.wdata[7:0];
    end
  end

  // =====================================================
  // accessory output
  logic acc_cmd;
  logic rc_mode;
  assign rc_mode = (mode == MCUIO_RC_DUAL);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_cmd <= 1'b0;
    end else if (bus.wr && bus.addr == OFS_CMD && !rc_mode) begin
      if (bus.wdata[7:0] == CMD_ACC_ON)
        acc_cmd <= 1'b1;
      else if (bus.wdata[7:0] == CMD_ACC_OFF)
        acc_cmd <= 1'b0;
    end
  end

  logic next_acc;
  always_comb begin
    next_acc = rc_mode ? (rc_ch3_level >= RC3_ON_LEVEL) : acc_cmd;
    if (auto_acc && motor_powered)
      next_acc = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_out    <= 1'b0;
      acc_out_oe <= 1'b0;
    end else begin
      acc_out    <= 1'b0;       // open drain pulls low when on
      acc_out_oe <= next_acc;
    end
  end

  // =====================================================
  // stop or invert handling, active low
  logic soi_active;
  logic gp_valid;
  assign soi_active = !soi_level;
  assign gp_valid   = !rc_mode && gp_level;

  logic hot;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      drive_enable      <= 1'b0;
      controls_inverted <= 1'b0;
      power_derate      <= 1'b0;
    end else begin
      drive_enable      <= !(soi_fn == MCUIO_ESTOP && soi_active);
      controls_inverted <= (soi_fn == MCUIO_INVERT) && soi_active;
      power_derate      <= hot;
    end
  end

  // =====================================================
  // analog readings and roles
  logic [7:0] sgn [4];
  logic [7:0] raw [4];
  assign raw[0] = ana_raw.a1;
  assign raw[1] = ana_raw.a2;
  assign raw[2] = ana_raw.a3;
  assign raw[3] = ana_raw.a4;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ana
      assign sgn[gi] = raw[gi] - ADC_OFFSET;
    end
  endgenerate

  logic [7:0] fb1;
  logic [7:0] fb2;
  always_comb begin
    fb1 = 8'h00;
    fb2 = 8'h00;
    case (mode)
      MCUIO_RC_DUAL, MCUIO_SER_DUAL: begin
        fb1 = sgn[0];
        fb2 = sgn[1];
      end
      MCUIO_ANA_DUAL: begin
        fb1 = sgn[2];
        fb2 = sgn[3];
      end
      MCUIO_SINGLE: fb1 = sgn[0];
      MCUIO_MIXED:  fb1 = sgn[2];
      default: begin
        fb1 = 8'h00;
        fb2 = 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      speed1_fb <= 8'h00;
      speed2_fb <= 8'h00;
      pos1_fb   <= 8'h00;
      pos2_fb   <= 8'h00;
    end else begin
      speed1_fb <= (loop_kind == MCUIO_SPEED) ? fb1 : 8'h00;
      speed2_fb <= (loop_kind == MCUIO_SPEED) ? fb2 : 8'h00;
      pos1_fb   <= (loop_kind == MCUIO_POS) ? fb1 : 8'h00;
      pos2_fb   <= (loop_kind == MCUIO_POS) ? fb2 : 8'h00;
    end
  end

  // thermistor reads lower when warmer
  assign hot = therm_en && (raw[therm_sel] < therm_hot);

  // =====================================================
  // interrupts
  logic [IRQ_W-1:0] int_st;
  logic [IRQ_W-1:0] int_en;
  logic [IRQ_W-1:0] ev;
  logic             gp_prev;
  logic             hot_prev;
  logic             soi_prev;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      gp_prev  <= 1'b0;
      hot_prev <= 1'b0;
      soi_prev <= 1'b0;
    end else begin
      gp_prev  <= gp_valid;
      hot_prev <= hot;
      soi_prev <= soi_active;
    end
  end

  assign ev[IRQ_STOP] = soi_active && !soi_prev && soi_fn == MCUIO_ESTOP;
  assign ev[IRQ_INV]  = soi_active && !soi_prev && soi_fn == MCUIO_INVERT;
  assign ev[IRQ_GPIN] = gp_valid != gp_prev;
  assign ev[IRQ_HOT]  = hot && !hot_prev;

  logic [IRQ_W-1:0] clr;
  assign clr = (bus.wr && bus.addr == OFS_INT_CLR) ? bus.wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      int_st <= '0;
      int_en <= '0;
      irq    <= 1'b0;
    end else begin
      int_st <= (int_st & ~clr) | ev;
      if (bus.wr && bus.addr == OFS_INT_EN)
        int_en <= bus.wdata[IRQ_W-1:0];
      irq <= |(((int_st & ~clr) | ev) & int_en);
    end
  end

  // =====================================================
  // read port, data one cycle after strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= 32'h0;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_CTRL:   rdata <= ctrl;
        // four groups: reserved, fixed off reply, general input, stop input
        OFS_STATUS: rdata <= {8'h00, REPLY_OFF,
                              gp_valid ? REPLY_ON : REPLY_OFF,
                              soi_level ? REPLY_ON : REPLY_OFF};
        OFS_ANA12:  rdata <= {16'h0, sgn[0], sgn[1]};
        OFS_ANA34:  rdata <= {16'h0, sgn[2], sgn[3]};
        OFS_INT_ST: rdata <= {{(32-IRQ_W){1'b0}}, int_st};
        OFS_INT_EN: rdata <= {{(32-IRQ_W){1'b0}}, int_en};
        OFS_THERM:  rdata <= {24'h0, therm_hot};
        OFS_CMD:    rdata <= {31'h0, acc_cmd};
        default:    rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // =====================================================
  // assertions
  a_estop_drive_off: assert property (@(posedge mclk) disable iff (!resetn)
    (soi_fn == MCUIO_ESTOP && soi_active) |=> !drive_enable)
    else $error("drive not disabled on stop");

  a_invert_follow: assert property (@(posedge mclk) disable iff (!resetn)
    (soi_fn == MCUIO_INVERT && soi_active) |=> controls_inverted)
    else $error("controls not inverted");

  a_noact_default: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && soi_fn == MCUIO_NOACT) |=> (drive_enable && !controls_inverted))
    else $error("stop input acted with no function");

  a_cmd_on_path: assert property (@(posedge mclk) disable iff (!resetn)
    (bus.wr && bus.addr == OFS_CMD && bus.wdata[7:0] == CMD_ACC_ON && !rc_mode)
      |=> ##1 acc_out_oe)
    else $error("accessory did not turn on");

  a_rc_acc: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && rc_mode && rc_ch3_level >= RC3_ON_LEVEL) |=> acc_out_oe)
    else $error("radio channel did not switch accessory");

  a_auto_acc: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && auto_acc && motor_powered) |=> acc_out_oe)
    else $error("accessory not on with motor");

  sequence s_status_read;
    bus.rd && bus.addr == OFS_STATUS && rc_mode;
  endsequence
  a_gp_rc_off: assert property (@(posedge mclk) disable iff (!resetn)
    s_status_read |=> rdata[15:8] == REPLY_OFF)
    else $error("general input reported in radio mode");

  sequence s_status_any;
    bus.rd && bus.addr == OFS_STATUS;
  endsequence
  a_gp_report: assert property (@(posedge mclk) disable iff (!resetn)
    s_status_any |=> rdata[15:8] == {7'h0, $past(gp_valid)})
    else $error("general input status wrong");

  a_soi_report: assert property (@(posedge mclk) disable iff (!resetn)
    s_status_any |=> rdata[7:0] == {7'h0, $past(soi_level)})
    else $error("stop input status wrong");

  a_ana_offset: assert property (@(posedge mclk) disable iff (!resetn)
    (bus.rd && bus.addr == OFS_ANA12) |=> rdata[15:8] == 8'($past(ana_raw.a1) - ADC_OFFSET))
    else $error("analog offset wrong");

  a_mixed_role: assert property (@(posedge mclk) disable iff (!resetn)
    (mode == MCUIO_MIXED && loop_kind == MCUIO_POS)
      |=> (pos1_fb == 8'($past(ana_raw.a3) - ADC_OFFSET) && pos2_fb == 8'h00))
    else $error("mixed mode roles wrong");

  a_derate_hot: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && hot) |=> power_derate)
    else $error("no derate when hot");

endmodule

`default_nettype wire

//--- bench/mcuio_pin_model.sv
// far side pins: open drain accessory load and a grounding stop switch
// assumes the accessory load pulls the pin up while the output is released
`timescale 1ns/1ps
`default_nettype none

module mcuio_pin_model (
  // from the block
  input  wire logic acc_out,
  input  wire logic acc_out_oe,
  // from the bench
  input  wire logic switch_closed,
  // pin levels
  output logic      acc_pin_level,
  output logic      soi_pin_level
);
  // =====================================================
  // pulled-up lines
  assign acc_pin_level = acc_out_oe ? acc_out : 1'b1;
  assign soi_pin_level = switch_closed ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

//--- bench/mcuio_top_tb.sv
// self-checking bench for the user i/o and analog routing block
// assumes the design package and the pin model are compiled first
`timescale 1ns/1ps
`default_nettype none

module mcuio_top_tb;
  import mcuio_pkg::*;
  logic        mclk = 1'b0;
  logic        resetn, gp, sw, motor, rd_q;
  logic        acc_out, acc_oe, drv_en, inv, derate, irq, acc_pin, soi_pin;
  logic [7:0]  rc, p1, p2, s1, s2;
  logic [15:0] seed;
  logic [31:0] rdata;
  mcuio_bus_s  bus;
  mcuio_ana_s  ana;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          err_count, checks_done;

  // =====================================================
  // clock and instances
  always #5 mclk = ~mclk;

  mcuio_pin_model i_pins (.acc_out(acc_out), .acc_out_oe(acc_oe), .switch_closed(sw),
                          .acc_pin_level(acc_pin), .soi_pin_level(soi_pin));

  mcuio_top i_dut (.mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata), .gp_input_pin(gp),
                   .stop_or_invert_input(soi_pin), .rc_ch3_level(rc), .acc_out(acc_out),
                   .acc_out_oe(acc_oe), .ana_raw(ana), .motor_powered(motor), .drive_enable(drv_en),
                   .controls_inverted(inv), .power_derate(derate), .speed1_fb(s1), .speed2_fb(s2),
                   .pos1_fb(p1), .pos2_fb(p2), .irq(irq));

  // =====================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] outv(input int k);
    case (k)
      0: return {7'h0, acc_oe};
      1: return {7'h0, drv_en};
      2: return {7'h0, inv};
      3: return {7'h0, derate};
      4: return {7'h0, irq};
      5: return p1;
      6: return p2;
      7: return s1;
      8: return s2;
      9: return {7'h0, acc_pin};
      default: return 8'h0;
    endcase
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    exp_q.push_back(exp);
    name_q.push_back(name);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic wait_out(input int k, input logic [7:0] exp, input string name);
    int n;
    n = 0;
    @(negedge mclk);
    while (outv(k) !== exp && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check(name, {24'h0, outv(k)}, {24'h0, exp});
    if (n >= 40) finish_test();
    @(posedge mclk);
  endtask

  // =====================================================
  // read data monitor: oldest note against the answer
  always @(posedge mclk) begin
    rd_q <= bus.rd;
    if (rd_q && exp_q.size() > 0) begin
      check(name_q.pop_front(), rdata, exp_q.pop_front());
    end
  end

  // =====================================================
  // main sequence
  initial begin
    resetn = 1'b0; bus = '0; gp = 1'b0; sw = 1'b0; motor = 1'b0;
    rc = 8'h00; ana = '{8'h80, 8'h80, 8'h80, 8'h80}; seed = 16'hef2c;
    err_count = 0; checks_done = 0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd(OFS_CTRL, CTRL_RESET, "ctrl_reset");
    wait_out(1, 8'h01, "drive_open_pin");
    rd(8'h3c, 32'h0, "unmapped");
    rc <= RC3_ON_LEVEL;
    wait_out(0, 8'h01, "rc_acc_on");
    wait_out(9, 8'h00, "acc_pin_low");
    rc <= 8'h7f;
    wait_out(0, 8'h00, "rc_acc_off");
    wr(OFS_CMD, {24'h0, CMD_ACC_ON});
    gp <= 1'b1;
    repeat (8) @(posedge mclk);
    wait_out(0, 8'h00, "cmd_in_rc");
    rd(OFS_STATUS, 32'h0000_0001, "status_rc");
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CMD, {24'h0, CMD_ACC_ON});
    wait_out(0, 8'h01, "cmd_on");
    wr(OFS_CMD, {24'h0, CMD_ACC_OFF});
    wait_out(0, 8'h00, "cmd_off");
    rd(OFS_STATUS, 32'h0000_0101, "status_ser");
    wr(OFS_INT_CLR, 32'hf);
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_CTRL, 32'h21);
    sw <= 1'b1;
    wait_out(1, 8'h00, "estop_drive");
    wait_out(4, 8'h01, "estop_irq");
    rd(OFS_STATUS, 32'h0000_0100, "status_stop");
    rd(OFS_INT_ST, 32'h1, "int_status");
    sw <= 1'b0;
    wait_out(1, 8'h01, "estop_release");
    wr(OFS_INT_CLR, 32'h1);
    wait_out(4, 8'h00, "irq_clear");
    rd(OFS_INT_CLR, 32'h0, "clr_reads_zero");
    wr(OFS_CTRL, 32'h41);
    sw <= 1'b1;
    wait_out(2, 8'h01, "invert_on");
    wait_out(1, 8'h01, "invert_drive");
    sw <= 1'b0;
    wait_out(2, 8'h00, "invert_off");
    wr(OFS_CTRL, 32'h1);
    sw <= 1'b1;
    repeat (8) @(posedge mclk);
    wait_out(1, 8'h01, "noact_drive");
    wait_out(2, 8'h00, "noact_inv");
    rd(OFS_STATUS, 32'h0000_0100, "noact_status");
    sw <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(lfsr(seed));
      ana <= '{seed[7:0], seed[15:8], seed[11:4], seed[3:0] ^ seed[15:12] ^ 8'h5a};
      @(posedge mclk);
      rd(OFS_ANA12, {16'h0, ana.a1 ^ ADC_OFFSET, ana.a2 ^ ADC_OFFSET}, "ana12");
      rd(OFS_ANA34, {16'h0, ana.a3 ^ ADC_OFFSET, ana.a4 ^ ADC_OFFSET}, "ana34");
    end
    wr(OFS_CTRL, 32'h09);
    wait_out(5, ana.a1 ^ ADC_OFFSET, "pos1_role");
    wait_out(6, ana.a2 ^ ADC_OFFSET, "pos2_role");
    wait_out(7, 8'h00, "speed1_unused");
    wr(OFS_CTRL, 32'h0b);
    wait_out(6, 8'h00, "single_pos2");
    wait_out(5, ana.a1 ^ ADC_OFFSET, "single_pos1");
    wr(OFS_CTRL, 32'h0c);
    wait_out(5, ana.a3 ^ ADC_OFFSET, "mixed_pos1");
    wr(OFS_CTRL, 32'h12);
    wait_out(7, ana.a3 ^ ADC_OFFSET, "speed1_role");
    wait_out(8, ana.a4 ^ ADC_OFFSET, "speed2_role");
    wait_out(5, 8'h00, "pos1_unused");
    ana.a3 <= 8'h80;
    wait_out(7, 8'h00, "speed_mid");
    ana.a3 <= 8'h00;
    wait_out(7, 8'h80, "speed_rev");
    ana.a3 <= 8'hff;
    wait_out(7, 8'h7f, "speed_fwd");
    wr(OFS_CTRL, 32'h81);
    motor <= 1'b1;
    wait_out(0, 8'h01, "auto_acc_on");
    motor <= 1'b0;
    wait_out(0, 8'h00, "auto_acc_off");
    ana.a1 <= 8'h10;
    wr(OFS_CTRL, 32'h101);
    wait_out(3, 8'h01, "therm_hot");
    ana.a1 <= 8'hf0;
    wait_out(3, 8'h00, "therm_cool");
    for (int n = 0; n < 10 && exp_q.size() > 0; n++) @(posedge mclk);
    if (exp_q.size() > 0) check("read_queue", exp_q.size(), 32'h0);
    finish_test();
  end
endmodule

`default_nettype wire
